// ---- pkg/pmbus_target_pkg.sv ----
// Purpose: shared constants and types of the two-wire register target
// Assumes: 25 MHz system clock, oversampling link clock
// Notes:   all widths are fixed; no software-visible bus on the core side
package pmbus_target_pkg;

    // fixed upper bits of the 7-bit target address
    localparam logic [2:0] ADDR_FIXED   = 3'h1;
    // number of user registers and their reset/unmapped values
    localparam logic [7:0] NUM_REGS     = 8'h07;
    localparam logic [7:0] REG_RESET    = 8'h00;
    localparam logic [7:0] UNMAPPED_RD  = 8'h00;
    // bit slots within one byte frame (8 data + 1 acknowledge)
    localparam logic [3:0] LAST_BIT     = 4'h7;
    localparam logic [3:0] ACK_SLOT     = 4'h8;
    localparam logic [3:0] ACK_DONE     = 4'h9;
    // strap code layout: [4:1] address bits, [0] light-load select
    localparam int unsigned STRAP_W     = 5;
    localparam int unsigned STRAP_ADDR_LSB = 1;
    localparam int unsigned STRAP_MODE_POS = 0;
    // settle time of the strap code after lockout release
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned SETTLE_NS     = 10000;
    localparam int unsigned SETTLE_CYC    =
        (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [8:0]  SETTLE_COUNT  = 9'(SETTLE_CYC);

    typedef logic [7:0] byte_t;
    typedef byte_t [6:0] regfile_t;

    // byte-level phases of the link engine
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA, ST_IGNORE
    } link_state_t;

endpackage : pmbus_target_pkg

// ---- pkg/strap_if.sv ----
// Purpose: carries the decoded strap result from decoder to target
// Assumes: one driver, the decoder
// Notes:   address bits are only meaningful while ready is high
`timescale 1ns/1ps
`default_nettype none
interface strap_if;
    logic       ready;       // lockout released and code settled
    logic [3:0] addrBits;    // low four address bits
    logic       forcedCont;  // 1: forced continuous, 0: skip
    modport decoder (output ready, addrBits, forcedCont);
    modport user    (input  ready, addrBits, forcedCont);
endinterface : strap_if
`default_nettype wire

// ---- design/strap_decoder.sv ----
// Purpose: catch the strap code once the bias supply leaves lockout
// Assumes: strap comparator code and lockout flag arrive asynchronously
// Notes:   code must hold steady for the settle time before it is taken
`timescale 1ns/1ps
`default_nettype none
module strap_decoder
    import pmbus_target_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               resetn,
    input  wire logic               supplyAboveLockout,
    input  wire logic [STRAP_W-1:0] strapCode,
    strap_if.decoder                strap
);

    ////////////////////////////////////////////////////////////////////
    // three-stage synchronisers; a change counts when stages 2 and 3 agree
    logic [STRAP_W:0] s1_r;      // first stage, read by s2 only
    logic [STRAP_W:0] s2_r;
    logic [STRAP_W:0] s3_r;
    logic [STRAP_W:0] filt_r;    // filtered {supply, code}
    logic [8:0]       settle_r;  // cycles the code has held

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s1_r   <= '0;
            s2_r   <= '0;
            s3_r   <= '0;
            filt_r <= '0;
        end else begin
            s1_r <= {supplyAboveLockout, strapCode};
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                filt_r <= s3_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // decode only above lockout; a code change restarts the settle wait
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            settle_r         <= '0;
            strap.ready      <= 1'b0;
            strap.addrBits   <= 4'h0;
            strap.forcedCont <= 1'b0;
        end else if (!filt_r[STRAP_W]) begin
            // below lockout: silent on the bus
            settle_r    <= '0;
            strap.ready <= 1'b0;
        end else if (!strap.ready) begin
            if (filt_r[STRAP_W-1:0] != s3_r[STRAP_W-1:0]) begin
                settle_r <= '0;
            end else if (settle_r == SETTLE_COUNT - 9'h001) begin
                // 32 levels: four address bits plus mode bit
                strap.addrBits   <= filt_r[STRAP_ADDR_LSB +: 4];
                strap.forcedCont <= filt_r[STRAP_MODE_POS];
                strap.ready      <= 1'b1;
            end else begin
                settle_r <= settle_r + 9'h001;
            end
        end
    end

    property p_lockoutHolds;
        @(posedge clock) disable iff (!resetn)
        !filt_r[STRAP_W] |=> !strap.ready;
    endproperty
    a_lockoutHolds: assert property (p_lockoutHolds)
        else $error("strap ready while supply is below lockout");

    property p_strapTaken;
        @(posedge clock) disable iff (!resetn)
        $rose(strap.ready) |->
            strap.addrBits == $past(filt_r[STRAP_ADDR_LSB +: 4]) &&
            strap.forcedCont == $past(filt_r[STRAP_MODE_POS]);
    endproperty
    a_strapTaken: assert property (p_strapTaken)
        else $error("strap fields differ from the settled code");

endmodule : strap_decoder
`default_nettype wire

// ---- design/pmbus_target_register_access.sv ----
// Purpose: two-wire bus target giving a host access to seven registers
// Assumes: linkClock oversamples the bus clock by far more than 8x
// Notes:   the bus engine runs on linkClock, register outputs on clock
`timescale 1ns/1ps
`default_nettype none

module pmbus_target_register_access
    import pmbus_target_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               resetn,
    input  wire logic               linkClock,
    input  wire logic               supplyAboveLockout,
    input  wire logic [STRAP_W-1:0] strapCode,
    input  wire logic               sclIn,
    input  wire logic               sdaIn,
    output logic                    sdaOut,
    output logic                    sdaOeN,
    output regfile_t                regValue,
    output logic [3:0]              strapAddressBits,
    output logic                    forcedContinuousSelect,
    output logic                    busEnabled
);

    ////////////////////////////////////////////////////////////////////
    // strap decoding in the system clock domain
    strap_if strapBus ();   // decoded strap result

    strap_decoder u_strap (
        .clock              (clock),
        .resetn             (resetn),
        .supplyAboveLockout (supplyAboveLockout),
        .strapCode          (strapCode),
        .strap              (strapBus)
    );

    assign strapAddressBits       = strapBus.addrBits;
    assign forcedContinuousSelect = strapBus.forcedCont;
    assign busEnabled             = strapBus.ready;

    ////////////////////////////////////////////////////////////////////
    // link-domain declarations
    logic [1:0]  lrst_r;      // reset release synchroniser
    logic        linkRstn;    // reset as seen on linkClock
    logic [1:0]  pinS1_r;     // {scl, sda} first stage
    logic [1:0]  pinS2_r;     // second stage
    logic [1:0]  pinS3_r;     // third stage
    logic        sclF_r;      // filtered bus clock
    logic        sdaF_r;      // filtered bus data
    logic        sclNew;      // filtered value for this edge
    logic        sdaNew;
    logic        sclRise;     // bus clock rising
    logic        sclFall;     // bus clock falling
    logic        startEv;     // start or repeated start
    logic        stopEv;      // stop condition
    logic        en1_r;       // ready synchroniser, stage one
    logic        enabled;     // ready on linkClock
    logic        en2_r;
    logic [3:0]  addrLink_r;  // strap address held on linkClock
    link_state_t state_r;     // byte phase
    logic [3:0]  bitCnt_r;    // bus clock rises in this byte
    logic [7:0]  shift_r;     // receive / transmit shifter
    logic        rw_r;        // direction bit of last address
    logic        sdaRel_r;    // 1: data line released
    logic [7:0]  pointer_r;   // register pointer
    regfile_t    regLink_r;   // bus-side copy of the registers
    logic [2:0]  wrIdx_r;     // last written index, held for crossing
    logic [7:0]  wrData_r;    // last written value, held for crossing
    logic        wrTog_r;     // flips once per register write
    logic        evFall;      // falling edge with no frame event
    logic        addrHit;     // received address is ours
    logic        ackCmd;      // register address byte taken
    logic        ackWrite;    // data byte taken
    logic [7:0]  readByte;    // byte returned to the host

    ////////////////////////////////////////////////////////////////////
    // reset for the link side: asserts at once, releases on linkClock
    always_ff @(posedge linkClock or negedge resetn) begin
        if (!resetn) begin
            lrst_r <= 2'h0;
        end else begin
            lrst_r <= {lrst_r[0], 1'b1};
        end
    end
    assign linkRstn = lrst_r[1];

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers; the oversampling margin covers all three bus
    // rates, and the stage two/three agreement filters single-sample glitches
    always_ff @(posedge linkClock or negedge linkRstn) begin
        if (!linkRstn) begin
            pinS1_r <= 2'h3;
            pinS2_r <= 2'h3;
            pinS3_r <= 2'h3;
            sclF_r  <= 1'b1;
            sdaF_r  <= 1'b1;
        end else begin
            pinS1_r <= {sclIn, sdaIn};
            pinS2_r <= pinS1_r;
            pinS3_r <= pinS2_r;
            sclF_r  <= sclNew;
            sdaF_r  <= sdaNew;
        end
    end

    // accept a level only once stages two and three agree
    assign sclNew = (pinS2_r[1] == pinS3_r[1]) ? pinS3_r[1] : sclF_r;
    assign sdaNew = (pinS2_r[0] == pinS3_r[0]) ? pinS3_r[0] : sdaF_r;

    // edge and frame events; data moving while clock high frames a byte
    assign sclRise = sclNew & ~sclF_r;
    assign sclFall = ~sclNew & sclF_r;
    assign startEv = sclF_r & sclNew & sdaF_r & ~sdaNew;
    assign stopEv  = sclF_r & sclNew & ~sdaF_r & sdaNew;

    ////////////////////////////////////////////////////////////////////
    // strap ready crossing; address bits are quasi-static: they are
    // sampled only while ready is still low here, so they have long
    // settled by the time the engine may use them
    always_ff @(posedge linkClock or negedge linkRstn) begin
        if (!linkRstn) begin
            en1_r      <= 1'b0;
            en2_r      <= 1'b0;
            addrLink_r <= 4'h0;
        end else begin
            en1_r <= strapBus.ready;
            en2_r <= en1_r;
            if (!en2_r) begin
                addrLink_r <= strapBus.addrBits;
            end
        end
    end
    assign enabled = en2_r;

    ////////////////////////////////////////////////////////////////////
    // decision strobes shared by the engine and the register store
    assign evFall   = enabled & ~startEv & ~stopEv & sclFall;
    // seven bits compared; ten-bit and legacy headers never match
    assign addrHit  = (shift_r[7:1] == {ADDR_FIXED, addrLink_r});
    assign ackCmd   = evFall && state_r == ST_CMD && bitCnt_r == ACK_SLOT;
    assign ackWrite = evFall && state_r == ST_WDATA
                      && bitCnt_r == ACK_SLOT;

    // unmapped pointers read a fixed value; writes to them are dropped
    assign readByte = (pointer_r < NUM_REGS) ? regLink_r[pointer_r[2:0]]
                                             : UNMAPPED_RD;

    ////////////////////////////////////////////////////////////////////
    // byte engine: frames, shifting, acknowledge and read drive
    always_ff @(posedge linkClock or negedge linkRstn) begin
        if (!linkRstn) begin
            state_r  <= ST_IDLE;
            bitCnt_r <= 4'h0;
            shift_r  <= 8'h00;
            rw_r     <= 1'b0;
            sdaRel_r <= 1'b1;
        end else if (!enabled) begin
            // lockout or strap not settled: never touch the line
            state_r  <= ST_IDLE;
            bitCnt_r <= 4'h0;
            sdaRel_r <= 1'b1;
        end else if (startEv) begin
            // start and repeated start both open an address phase
            state_r  <= ST_ADDR;
            bitCnt_r <= 4'h0;
            sdaRel_r <= 1'b1;
        end else if (stopEv) begin
            state_r  <= ST_IDLE;
            sdaRel_r <= 1'b1;
        end else if (sclRise) begin
            case (state_r)
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    // sample data bits, not our own acknowledge
                    if (bitCnt_r <= LAST_BIT) begin
                        shift_r <= {shift_r[6:0], sdaF_r};
                    end
                    bitCnt_r <= bitCnt_r + 4'h1;
                end
                ST_RDATA: begin
                    // ninth clock carries the host's answer; a single
                    // byte is returned whatever it says
                    if (bitCnt_r == ACK_SLOT) begin
                        state_r <= ST_IGNORE;
                    end
                    bitCnt_r <= bitCnt_r + 4'h1;
                end
                default: begin
                    // idle or ignoring: wait for a frame event
                end
            endcase
        end else if (sclFall) begin
            case (state_r)
                ST_ADDR: begin
                    if (bitCnt_r == ACK_SLOT) begin
                        if (addrHit) begin
                            sdaRel_r <= 1'b0;
                            rw_r     <= shift_r[0];
                        end else begin
                            // not ours: stay released to the next start or stop
                            state_r <= ST_IGNORE;
                        end
                    end else if (bitCnt_r == ACK_DONE) begin
                        bitCnt_r <= 4'h0;
                        if (rw_r) begin
                            // read: pointed byte, msb on this fall
                            state_r  <= ST_RDATA;
                            shift_r  <= readByte;
                            sdaRel_r <= readByte[7];
                        end else begin
                            state_r  <= ST_CMD;
                            sdaRel_r <= 1'b1;
                        end
                    end
                end
                ST_CMD: begin
                    if (bitCnt_r == ACK_SLOT) begin
                        sdaRel_r <= 1'b0;
                    end else if (bitCnt_r == ACK_DONE) begin
                        sdaRel_r <= 1'b1;
                        state_r  <= ST_WDATA;
                        bitCnt_r <= 4'h0;
                    end
                end
                ST_WDATA: begin
                    if (bitCnt_r == ACK_SLOT) begin
                        sdaRel_r <= 1'b0;
                    end else if (bitCnt_r == ACK_DONE) begin
                        // one data byte per write; more get no ack
                        sdaRel_r <= 1'b1;
                        state_r  <= ST_IGNORE;
                    end
                end
                ST_RDATA: begin
                    if (bitCnt_r == ACK_SLOT) begin
                        sdaRel_r <= 1'b1;
                    end else if (bitCnt_r <= LAST_BIT) begin
                        sdaRel_r <= shift_r[6];
                        shift_r  <= {shift_r[6:0], 1'b0};
                    end
                end
                default: begin
                    sdaRel_r <= 1'b1;
                end
            endcase
        end
    end

    // open-drain data pin: drive low only, enable is active low
    assign sdaOut = 1'b0;
    assign sdaOeN = sdaRel_r;

    ////////////////////////////////////////////////////////////////////
    // pointer: loaded only by a register address byte, never stepped,
    // and untouched by stops or traffic to other targets
    always_ff @(posedge linkClock or negedge linkRstn) begin
        if (!linkRstn) begin
            pointer_r <= 8'h00;
        end else if (ackCmd) begin
            pointer_r <= shift_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus-side register store; each write also flips the crossing
    // toggle, with index and value held until the next write
    always_ff @(posedge linkClock or negedge linkRstn) begin
        if (!linkRstn) begin
            regLink_r <= {7{REG_RESET}};
            wrIdx_r   <= 3'h0;
            wrData_r  <= 8'h00;
            wrTog_r   <= 1'b0;
        end else if (ackWrite && pointer_r < NUM_REGS) begin
            regLink_r[pointer_r[2:0]] <= shift_r;
            wrIdx_r   <= pointer_r[2:0];
            wrData_r  <= shift_r;
            wrTog_r   <= ~wrTog_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // write crossing into the system clock; a whole byte frame passes
    // before the held index and value can change, far beyond the sync
    logic wrS1_r;   // toggle, first stage
    logic wrS2_r;   // toggle, second stage
    logic wrS3_r;   // toggle, edge reference
    logic wrEvent;  // one pulse per register write
    regfile_t regCore_r;  // registers seen by the regulator

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wrS1_r <= 1'b0;
            wrS2_r <= 1'b0;
            wrS3_r <= 1'b0;
        end else begin
            wrS1_r <= wrTog_r;
            wrS2_r <= wrS1_r;
            wrS3_r <= wrS2_r;
        end
    end
    assign wrEvent = wrS2_r ^ wrS3_r;

    // one update process per register
    for (genvar i = 0; i < 7; i++) begin : g_reg
        always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
                regCore_r[i] <= REG_RESET;
            end else if (wrEvent && wrIdx_r == 3'(i)) begin
                regCore_r[i] <= wrData_r;
            end
        end
    end
    assign regValue = regCore_r;

    ////////////////////////////////////////////////////////////////////
    // checks on the link engine and the write crossing
    property p_silentLocked;
        @(posedge linkClock) disable iff (!linkRstn)
        !enabled |=> sdaRel_r;
    endproperty
    a_silentLocked: assert property (p_silentLocked)
        else $error("data line driven before the bus is enabled");

    property p_ackOwn;
        @(posedge linkClock) disable iff (!linkRstn)
        evFall && state_r == ST_ADDR && bitCnt_r == ACK_SLOT
            && shift_r[7:1] == {ADDR_FIXED, addrLink_r}
        |=> !sdaRel_r;
    endproperty
    a_ackOwn: assert property (p_ackOwn)
        else $error("own address not acknowledged");

    property p_ignoreReleased;
        @(posedge linkClock) disable iff (!linkRstn)
        state_r == ST_IGNORE || state_r == ST_IDLE |-> sdaRel_r;
    endproperty
    a_ignoreReleased: assert property (p_ignoreReleased)
        else $error("data line held while not addressed");

    property p_pointerStable;
        @(posedge linkClock) disable iff (!linkRstn)
        !ackCmd |=> $stable(pointer_r);
    endproperty
    a_pointerStable: assert property (p_pointerStable)
        else $error("pointer moved without a register address byte");

    property p_readPointed;
        @(posedge linkClock) disable iff (!linkRstn)
        $rose(state_r == ST_RDATA) |->
            shift_r == $past(readByte) && sdaRel_r == shift_r[7];
    endproperty
    a_readPointed: assert property (p_readPointed)
        else $error("read byte not taken from the pointer");

    property p_direction;
        @(posedge linkClock) disable iff (!linkRstn)
        $rose(state_r == ST_CMD) |-> !rw_r;
    endproperty
    a_direction: assert property (p_direction)
        else $error("register phase entered on a read address");

    property p_restart;
        @(posedge linkClock) disable iff (!linkRstn)
        enabled && startEv |=> state_r == ST_ADDR && bitCnt_r == 4'h0;
    endproperty
    a_restart: assert property (p_restart)
        else $error("start did not open an address phase");

    property p_singleWrite;
        @(posedge linkClock) disable iff (!linkRstn)
        evFall && state_r == ST_WDATA && bitCnt_r == ACK_DONE
        |=> state_r == ST_IGNORE ##1 sdaRel_r;
    endproperty
    a_singleWrite: assert property (p_singleWrite)
        else $error("second data byte accepted in one write");

    property p_writeLands;
        @(posedge clock) disable iff (!resetn)
        wrEvent |=> regCore_r[$past(wrIdx_r)] == $past(wrData_r);
    endproperty
    a_writeLands: assert property (p_writeLands)
        else $error("written byte not seen in the output registers");

endmodule : pmbus_target_register_access
`default_nettype wire

// ---- verif/bus_host_model.sv ----
// Purpose: two-wire bus host driving clock and data toward the target
// Assumes: open-drain data with pull-up, host owns the bus clock
// Notes:   three phases per bit so data never moves while clock is high
`timescale 1ns/1ps
`default_nettype none
module bus_host_model (
    input  wire logic clock,
    input  wire logic sdaOut,
    input  wire logic sdaOeN,
    output logic      sclIn,
    output logic      sdaIn
);
    logic hostSda;  // host drive, 1 = released
    int   phaseLen = 8;  // clocks a phase: 8 near 1 Mbit/s, 21 near 400k, 83 near 100k
    // wired-and: pulled high unless someone pulls low
    assign sdaIn = hostSda & (sdaOeN | sdaOut);
    initial begin
        sclIn = 1'b1;
        hostSda = 1'b1;
    end
    // even the shortest phase keeps ~50 link clocks per phase
    task automatic phase(input logic s, input logic d);
        sclIn <= s;
        hostSda <= d;
        repeat (phaseLen) @(posedge clock);
    endtask : phase
    task automatic start();  // also a repeated start
        phase(1'b0, 1'b1);
        phase(1'b1, 1'b1);
        phase(1'b1, 1'b0);
    endtask : start
    task automatic stop();
        phase(1'b0, 1'b0);
        phase(1'b1, 1'b0);
        phase(1'b1, 1'b1);
    endtask : stop
    task automatic bitx(input logic b, output logic r);
        phase(1'b0, hostSda);
        phase(1'b0, b);
        phase(1'b1, b);
        r = sdaIn;
    endtask : bitx
    // msb first; ack slot left released, so a read byte gets a nack
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
        bitx(1'b1, ack);
    endtask : xfer
endmodule : bus_host_model
`default_nettype wire

// ---- verif/pmbus_target_register_access_tb.sv ----
// Purpose: self-checking bench of the register target
// Assumes: host model on the bus, random strap code
// Notes:   expectations come from a local register copy
`timescale 1ns/1ps
`default_nettype none
module pmbus_target_register_access_tb
    import pmbus_target_pkg::*;
;
    logic clock = 1'b0, linkClock = 1'b0, resetn, supply, sclIn, sdaIn, sdaOut, sdaOeN;
    logic forced, busEnabled;
    logic [STRAP_W-1:0] code;
    logic [3:0] strapBits;
    regfile_t regValue;
    byte_t model [0:7];  // expected contents, slot 7 unmapped
    logic [6:0] me;
    int miscompares = 0, totalChecks = 0;
    initial forever #20 clock = ~clock;
    initial begin
        #1.3;
        forever #3 linkClock = ~linkClock;
    end
    pmbus_target_register_access dut (.clock(clock), .resetn(resetn), .linkClock(linkClock),
        .supplyAboveLockout(supply), .strapCode(code), .sclIn(sclIn), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOeN(sdaOeN), .regValue(regValue), .strapAddressBits(strapBits),
        .forcedContinuousSelect(forced), .busEnabled(busEnabled));
    bus_host_model host (.clock(clock), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .sclIn(sclIn),
        .sdaIn(sdaIn));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        totalChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic sendb(input logic [7:0] tx, input logic expAck);
        logic [7:0] rx;
        logic ack;
        host.xfer(tx, rx, ack);
        check("ack", {7'h00, expAck}, {7'h00, ack});
    endtask : sendb
    task automatic recvb(input logic [7:0] exp);
        logic [7:0] rx;
        logic ack;
        host.xfer(8'hff, rx, ack);
        check("read byte", exp, rx);
    endtask : recvb
    // pointer set then combined read through a repeated start
    task automatic rdReg(input logic [7:0] r);
        host.start();
        sendb({me, 1'b0}, 1'b0);
        sendb(r, 1'b0);
        host.start();
        sendb({me, 1'b1}, 1'b0);
        recvb(model[r[2:0]]);
        host.stop();
    endtask : rdReg
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    function automatic logic [6:0] addrOf(input logic [STRAP_W-1:0] c);
        return {ADDR_FIXED, c[4:1]};
    endfunction : addrOf
    initial begin
        repeat (80000) @(posedge clock);
        miscompares++;
        give_verdict();
    end
    initial begin
        void'($urandom(50767));
        resetn = 1'b0;
        supply = 1'b0;
        code = STRAP_W'($urandom);
        me = addrOf(code);
        model[7] = UNMAPPED_RD;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        host.start();
        sendb({me, 1'b0}, 1'b1);
        host.stop();
        check("bus enabled", 8'h00, {7'h00, busEnabled});
        supply <= 1'b1;
        for (int n = 0; n < 1000 && busEnabled !== 1'b1; n++) @(posedge clock);
        check("bus enabled", 8'h01, {7'h00, busEnabled});
        check("strap address", {4'h0, code[4:1]}, {4'h0, strapBits});
        check("strap mode", {7'h00, code[0]}, {7'h00, forced});
        repeat (4) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            if (i < 7) model[i] = byte_t'($urandom);
            host.start();
            sendb({me, 1'b0}, 1'b0);
            sendb(8'(i), 1'b0);
            sendb(i < 7 ? model[i] : 8'ha5, 1'b0);
            if (i == 7) sendb(8'h5a, 1'b1);
            host.stop();
        end
        repeat (8) @(posedge clock);
        for (int i = 0; i < 7; i++) check("register", model[i], regValue[i]);
        for (int i = 7; i >= 0; i--) rdReg(8'(i));
        // same write and read-back at the two slower bus rates
        for (int k = 0; k < 2; k++) begin
            host.phaseLen = (k == 0) ? 83 : 21;
            model[2 + k] = byte_t'($urandom);
            host.start();
            sendb({me, 1'b0}, 1'b0);
            sendb(8'(2 + k), 1'b0);
            sendb(model[2 + k], 1'b0);
            host.stop();
            rdReg(8'(2 + k));
            check("register", model[2 + k], regValue[2 + k]);
        end
        host.phaseLen = 8;
        host.start();
        sendb({me, 1'b0}, 1'b0);
        sendb(8'h03, 1'b0);
        host.stop();
        host.start();
        sendb({me ^ 7'h08, 1'b0}, 1'b1);
        host.start();
        sendb(8'hf0, 1'b1);
        host.stop();
        repeat (2) begin
            host.start();
            sendb({me, 1'b1}, 1'b0);
            recvb(model[3]);
            host.stop();
        end
        give_verdict();
    end
endmodule : pmbus_target_register_access_tb
`default_nettype wire
